// *** bench/conv_model.sv ***
// Converter model: answers each start pulse with one 16-bit word.
// Assumes the block pulses start for one cycle with the channel beside it.
`timescale 1ns/1ps
module conv_model (
    // Request from the block
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [1:0] chan_i,
    input wire logic [63:0] vals_i,
    input wire logic slow_i,
    // Link pins
    output logic sclk_o,
    output logic frame_o,
    output logic data_o
);
    logic [15:0] word;

    // Clock stands low between frames; data then shows the inverse
    initial
    begin
        sclk_o = 1'b0;
        frame_o = 1'b0;
        data_o = 1'b0;
        forever
        begin
            @(posedge clk_i);
            if (start_i === 1'b1)
            begin
                word = vals_i[{chan_i, 4'h0} +: 16];
                #(slow_i ? 40000 : 300);
                frame_o = 1'b1;
                for (int i = 15; i >= 0; i--)
                begin
                    data_o = word[i];
                    #400 sclk_o = 1'b1;
                    #400 sclk_o = 1'b0;
                end
                #400 frame_o = 1'b0;
                data_o = ~word[0];
            end
        end
    end
endmodule : conv_model

// *** bench/monitor_channels_and_alarm_outputs_test.sv ***
// Self-checking bench for the monitor block with a converter model.
// Assumes a 10 MHz clock and a shortened frame of 4000 cycles.
`timescale 1ns/1ps
module monitor_channels_and_alarm_outputs_test;
    import monitor_pkg::*;
    logic clk_i, rst_i, ack, irq, start, sclk, frame, sdata;
    logic in_a, in_b, wp, rdis, slow, out_a, oe_a, out_b, oe_b, hiz;
    logic [1:0] chan;
    logic [7:0] res0, res1;
    logic [31:0] rdat;
    logic [63:0] vals, note;
    logic [63:0] notes[$];
    logic [15:0] hi_t[4] = '{16'h8000, 16'hFF00, 16'hF000, 16'h0500};
    logic [15:0] lo_t[4] = '{16'h1000, 16'h0100, 16'h0010, 16'hFB00};
    logic [11:0] st;
    logic [15:0] r;
    wb_req_type wb;
    int error_cnt = 0;
    int total_checks = 0;

    monitor_channels_and_alarm_outputs #(.FRAME_CYCLES_P(4000))
        monitor_channels_and_alarm_outputs_inst (.clk_i(clk_i),
        .rst_i(rst_i), .wb_i(wb), .wb_ack_o(ack), .wb_dat_o(rdat),
        .irq_o(irq), .conv_start_o(start), .conv_chan_o(chan),
        .link_sclk_i(sclk), .link_frame_i(frame), .link_data_i(sdata),
        .buffer_in_a_i(in_a), .buffer_in_b_i(in_b),
        .write_protect_pin_i(wp), .resistor_disable_in_i(rdis),
        .alarm_buffer_out_a_o(out_a), .alarm_buffer_out_a_oe_o(oe_a),
        .buffer_out_b_o(out_b), .buffer_out_b_oe_o(oe_b),
        .resistor0_setting_o(res0), .resistor1_setting_o(res1),
        .resistor_hiz_o(hiz));

    conv_model conv_model_inst (.clk_i(clk_i), .start_i(start),
        .chan_i(chan), .vals_i(vals), .slow_i(slow), .sclk_o(sclk),
        .frame_o(frame), .data_o(sdata));

    // Clock
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        chk({24'h0, got}, {24'h0, exp});
    endtask : chk_pin

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        wb <= '{1'b1, 1'b1, w, a, 4'hF, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        wb.cyc <= 1'b0;
        wb.stb <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        notes.push_back({m, e & m});
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Results, each the converter word with its low four bits cleared
    task automatic check_results();
        for (int c = 0; c < 4; c++)
            rd(ADR_RESULT + 12'(4 * c), {16'h0, vals[c*16 +: 16] & RESULT_KEEP},
               32'h0000_FFFF);
    endtask : check_results

    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask : settle

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Read monitor: oldest note against the data beside each read ack
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && wb.we === 1'b0 && notes.size() > 0)
        begin
            note = notes.pop_front();
            chk(rdat & note[63:32], note[31:0]);
        end
    end

    // Watchdog
    initial
    begin
        #4_000_000;
        error_cnt++;
        close_out();
    end

    // Main sequence
    initial
    begin
        wb = '0;
        {in_a, in_b, wp, slow} = 4'h0;
        rdis = 1'b1;
        rst_i = 1'b1;
        void'($urandom(26));
        vals = {16'hF600, 16'h0000, 16'hFFFF, 16'($urandom)};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ADR_CTRL, 32'h0000_0001, CTRL_USED);
        rd(ADR_STATUS, 32'h0000_0000, 32'h0000_0FFF);
        rd(12'hFF0, 32'h0000_0000, 32'hFFFF_FFFF);
        chk_pin(oe_a, 1'b1);
        chk_pin(oe_b, 1'b1);
        chk_pin(hiz, 1'b1);
        st = 12'h00F;
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, ADR_LIMIT + 12'(8 * c), {16'h0, hi_t[c]});
            bus(1'b1, ADR_LIMIT + 12'(8 * c + 4), {16'h0, lo_t[c]});
            r = vals[c*16 +: 16] & RESULT_KEEP;
            st[HI_LSB + c] = c == 3 ? $signed(r) > $signed(hi_t[c])
                                    : r > hi_t[c];
            st[LO_LSB + c] = c == 3 ? $signed(r) < $signed(lo_t[c])
                                    : r < lo_t[c];
        end
        bus(1'b1, ADR_MASK, {20'h0, ALARM_BITS});
        repeat (5) @(posedge clk_i iff start === 1'b1);
        check_results();
        rd(ADR_STATUS, {20'h0, st}, 32'h0000_0FFF);
        chk_pin(irq, 1'b1);
        chk_pin(oe_a, 1'b1);
        bus(1'b1, ADR_CTRL, 32'h0000_0003);
        settle();
        chk_pin(oe_a, 1'b0);
        vals <= {16'h0000, 16'h1000, 16'h1000, 16'h4000};
        slow <= 1'b1;
        repeat (5) @(posedge clk_i iff start === 1'b1);
        check_results();
        rd(ADR_STATUS, {20'h0, st}, {20'h0, ALARM_BITS});
        bus(1'b1, ADR_STATUS, {20'h0, ALARM_BITS});
        rd(ADR_STATUS, 32'h0000_0000, {20'h0, ALARM_BITS});
        settle();
        chk_pin(irq, 1'b0);
        chk_pin(oe_a, 1'b1);
        in_a <= 1'b1;
        in_b <= 1'b1;
        rdis <= 1'b0;
        settle();
        chk_pin(oe_a, 1'b0);
        chk_pin(oe_b, 1'b0);
        chk_pin({out_a, out_b}, 2'b00);
        chk_pin(hiz, 1'b0);
        bus(1'b1, ADR_LUT + 12'h050, 32'h0000_A53C);
        repeat (5) @(posedge clk_i iff start === 1'b1);
        chk_pin(res0, 8'h3C);
        chk_pin(res1, 8'hA5);
        bus(1'b1, ADR_CTRL, 32'h0000_0007);
        wp <= 1'b1;
        settle();
        bus(1'b1, ADR_CTRL, 32'h0000_5A00);
        rd(ADR_CTRL, 32'h0000_0007, CTRL_USED);
        bus(1'b1, ADR_LIMIT, 32'h0000_1234);
        rd(ADR_LIMIT, {16'h0, hi_t[0]}, 32'h0000_FFFF);
        wp <= 1'b0;
        settle();
        bus(1'b1, ADR_CTRL, 32'h0000_5A00);
        rd(ADR_CTRL, 32'h0000_5A00, CTRL_USED);
        settle();
        chk_pin(res0, 8'h5A);
        rdis <= 1'b1;
        settle();
        chk_pin(hiz, 1'b1);
        rd(ADR_PINS, 32'h0002_005A, 32'h0003_FFFF);
        close_out();
    end
endmodule : monitor_channels_and_alarm_outputs_test

// *** core/monitor_channels_and_alarm_outputs.sv ***
// Four-channel monitor with limit alarms, resistor setting selection,
// buffers and a Wishbone register slave.
// Assumes an external converter that converts the requested channel and
// returns the word over a serial link; pins are asynchronous to clk_i.
//
// Notes on behaviour
// - Results are 16 bits, left-justified, 12 significant bits; low four cleared.
// - Channels refresh in round-robin, each once per conversion frame period.
// - A per-channel done bit is set when that channel finishes converting.
// - Each result is compared with high and low limits; alarm flag set.
// - Each channel has its own interrupt enable for its alarms.
// - Alarm buffer output A may also assert on any enabled limit alarm.
// - Two buffers drive open-drain outputs from logic-level inputs.
// - Resistor disable input high puts both resistors in high impedance.
// - Write protect pin low means memory is never write protected.
// - Each resistor has its own setting per 2 degree step, -40 to +102.
// - Temperature results are two's complement, 7FFF top, 8000 bottom.
// - Supply and analog input results are unsigned, 0000 is zero volts.
// - Supply result unit is 100 microvolts, FFFF is 6.55 V.
// - Analog input unit is 38.147 microvolts, FFFF is 2.5 V.
// - Resistor settings come from a temperature-addressed table, 00h..FFh.
// - With temperature indexing off, resistors use the manual bytes.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module monitor_channels_and_alarm_outputs
    import monitor_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES_P = monitor_pkg::FRAME_CYCLES
)
(
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input monitor_pkg::wb_req_type wb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic irq_o,
    // Converter request and result link
    output logic conv_start_o,
    output logic [1:0] conv_chan_o,
    input wire logic link_sclk_i,
    input wire logic link_frame_i,
    input wire logic link_data_i,
    // Buffers and control pins
    input wire logic buffer_in_a_i,
    input wire logic buffer_in_b_i,
    input wire logic write_protect_pin_i,
    input wire logic resistor_disable_in_i,
    output logic alarm_buffer_out_a_o,
    output logic alarm_buffer_out_a_oe_o,
    output logic buffer_out_b_o,
    output logic buffer_out_b_oe_o,
    // Resistor settings
    output logic [7:0] resistor0_setting_o,
    output logic [7:0] resistor1_setting_o,
    output logic resistor_hiz_o
);
    import monitor_pkg::*;

    localparam int unsigned SLOT_CYCLES = FRAME_CYCLES_P / NUM_CHAN;
    localparam logic [17:0] SLOT_LAST = 18'(SLOT_CYCLES - 1);
    localparam logic [7:0] LUT_BASE_W = ADR_LUT[9:2];
    localparam logic [7:0] LUT_END_W = 8'(LUT_DEPTH) + ADR_LUT[9:2];

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_COLLECT = 3'b010,
        SEQ_HOLD = 3'b100
    } seq_type;

    // Byte-lane merge for writes
    function automatic logic [31:0] merge32(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : merge32

    // Limit comparison, signed for temperature, unsigned otherwise
    function automatic logic above(input logic [15:0] a,
        input logic [15:0] b, input logic sgn);
        return sgn ? ($signed(a) > $signed(b)) : (a > b);
    endfunction : above

    // Table index from the integer degrees of the temperature result
    function automatic logic [6:0] temp_index(input logic [7:0] t);
        logic signed [9:0] s;
        s = $signed({{2{t[7]}}, t}) - $signed(10'(TEMP_MIN_C));
        if (s < 0)
            return 7'd0;
        else if (s > $signed(10'(TEMP_MAX_C - TEMP_MIN_C)))
            return 7'(LUT_DEPTH - 1);
        else
            return s[7:1];
    endfunction : temp_index

    conv_word_type word;
    seq_type seq_q;
    seq_type seq_d;
    logic [17:0] slot_q;
    logic [1:0] chan_q;
    logic start_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic irq_q;
    logic [31:0] ctrl_q;
    logic [11:0] status_q;
    logic [11:0] mask_q;
    logic [15:0] result_q [NUM_CHAN];
    logic [15:0] hi_q [NUM_CHAN];
    logic [15:0] lo_q [NUM_CHAN];
    logic [15:0] lut_q [LUT_DEPTH];
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic outa_oe_q;
    logic outb_oe_q;
    logic [7:0] res0_q;
    logic [7:0] res1_q;
    logic hiz_q;

    // Converter words come in over the slow link
    result_link_rx link_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .link_sclk_i(link_sclk_i),
        .link_frame_i(link_frame_i),
        .link_data_i(link_data_i),
        .word_o(word)
    );

    // Synchronised pins: in_a, in_b, write protect, resistor disable
    wire in_a_s = pin_sync_q[0];
    wire in_b_s = pin_sync_q[1];
    wire wp_s = pin_sync_q[2];
    wire hiz_s = pin_sync_q[3];

    // Bus decode
    wire req = wb_i.cyc & wb_i.stb;
    wire [7:0] wadr = wb_i.adr[9:2];
    wire top_zero = wb_i.adr[11:10] == 2'b00;
    wire hit_ctrl = wb_i.adr == ADR_CTRL;
    wire hit_status = wb_i.adr == ADR_STATUS;
    wire hit_mask = wb_i.adr == ADR_MASK;
    wire hit_pins = wb_i.adr == ADR_PINS;
    wire hit_res = wb_i.adr[11:4] == ADR_RESULT[11:4];
    wire hit_lim = wb_i.adr[11:5] == ADR_LIMIT[11:5];
    wire hit_lut = top_zero && wadr >= LUT_BASE_W && wadr < LUT_END_W;
    wire [1:0] res_ch = wb_i.adr[3:2];
    wire [1:0] lim_ch = wb_i.adr[4:3];
    wire lim_low = wb_i.adr[2];
    wire [7:0] lut_off = wadr - LUT_BASE_W;
    wire [6:0] lut_idx = lut_off[6:0];

    // Writes commit at the edge where the master sees ack
    wire wr_fire = req & wb_i.we & ack_q;
    wire locked = wp_s & ctrl_q[CTRL_PROTECT_BIT];
    wire wr_open = wr_fire & ~locked;
    wire [31:0] lim_cur = {16'h0000, lim_low ? lo_q[lim_ch] : hi_q[lim_ch]};
    wire [31:0] lim_new = merge32(lim_cur, wb_i.dat, wb_i.sel);
    wire [31:0] lut_new = merge32({16'h0000, lut_q[lut_idx]}, wb_i.dat,
        wb_i.sel);
    wire [31:0] ctrl_new = merge32(ctrl_q, wb_i.dat, wb_i.sel) & CTRL_USED;
    wire [31:0] clr_word = merge32(32'h0000_0000, wb_i.dat, wb_i.sel);
    wire [11:0] status_clr = (wr_fire & hit_status) ? clr_word[11:0] : 12'h000;
    wire [31:0] mask_new = merge32({20'h00000, mask_q}, wb_i.dat, wb_i.sel);

    // Read data selection; unmapped addresses read zero
    wire [31:0] rd_pins = {14'h0000, hiz_q, wp_s, res1_q, res0_q};
    wire [31:0] rd_lim = lim_cur;
    wire [31:0] rd_data =
        hit_ctrl ? ctrl_q :
        hit_status ? {20'h00000, status_q} :
        hit_mask ? {20'h00000, mask_q} :
        hit_pins ? rd_pins :
        hit_res ? {16'h0000, result_q[res_ch]} :
        hit_lim ? rd_lim :
        hit_lut ? {16'h0000, lut_q[lut_idx]} : 32'h0000_0000;

    // Incoming result: drop the four bits below 12-bit accuracy
    wire take = word.valid & (seq_q == SEQ_COLLECT);
    wire [15:0] new_res = word.data & RESULT_KEEP;
    wire sgn = chan_q == CH_TEMP;
    wire over_hi = above(new_res, hi_q[chan_q], sgn);
    wire under_lo = above(lo_q[chan_q], new_res, sgn);
    wire [11:0] one_hot = {8'h00, 4'(4'b0001 << chan_q)};
    wire [11:0] status_set = take ?
        (one_hot << DONE_LSB) | ((over_hi ? one_hot : 12'h000) << HI_LSB) |
        ((under_lo ? one_hot : 12'h000) << LO_LSB) : 12'h000;
    wire [11:0] status_d = (status_q & ~status_clr) | status_set;

    // Slot timing: each channel owns a quarter of the frame
    wire slot_end = slot_q == SLOT_LAST;
    wire [11:0] enabled = status_q & mask_q;
    wire alarm_out = |(enabled & ALARM_BITS);
    wire outa_release = in_a_s | (ctrl_q[CTRL_OUTA_ALARM_BIT] & alarm_out);
    wire [6:0] tidx = temp_index(result_q[CH_TEMP][15:8]);
    wire [15:0] lut_sel = lut_q[tidx];
    wire tie = ctrl_q[CTRL_TIE_BIT];

    // Sequencer next state
    always_comb
    begin
        seq_d = seq_q;
        case (seq_q)
            SEQ_IDLE: seq_d = slot_end ? SEQ_COLLECT : SEQ_IDLE;
            SEQ_COLLECT: seq_d = slot_end ? SEQ_COLLECT :
                (take ? SEQ_HOLD : SEQ_COLLECT);
            SEQ_HOLD: seq_d = slot_end ? SEQ_COLLECT : SEQ_HOLD;
            default: seq_d = SEQ_IDLE;
        endcase
    end

    // Round-robin request of the next channel at each slot end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seq_q <= SEQ_IDLE;
            slot_q <= 18'd0;
            chan_q <= CH_TEMP;
            start_q <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
            slot_q <= slot_end ? 18'd0 : slot_q + 18'd1;
            start_q <= slot_end;
            if (slot_end)
                chan_q <= chan_q + 2'd1;
        end
    end

    // Bus handshake: ack one cycle after the request, then drop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q)
                rdat_q <= rd_data;
        end
    end

    // Control, status and mask registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= CTRL_RESET;
            status_q <= STATUS_RESET;
            mask_q <= 12'h000;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
            if (wr_open & hit_ctrl)
                ctrl_q <= ctrl_new;
            if (wr_fire & hit_mask)
                mask_q <= mask_new[11:0];
        end
    end

    // Results stored in the same edge as their done bit
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            result_q <= '{default: 16'h0000};
        else if (take)
            result_q[chan_q] <= new_res;
    end

    // Limits and resistor table, writable unless locked
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hi_q <= '{HI_RESET_UNS, HI_RESET_UNS, HI_RESET_UNS, HI_RESET_SGN};
            lo_q <= '{LO_RESET_UNS, LO_RESET_UNS, LO_RESET_UNS, LO_RESET_SGN};
            lut_q <= '{default: LUT_RESET};
        end
        else
        begin
            if (wr_open & hit_lim & lim_low)
                lo_q[lim_ch] <= lim_new[15:0];
            if (wr_open & hit_lim & ~lim_low)
                hi_q[lim_ch] <= lim_new[15:0];
            if (wr_open & hit_lut)
                lut_q[lut_idx] <= lut_new[15:0];
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_q <= 4'hC;
            pin_sync_q <= 4'hC;
        end
        else
        begin
            pin_meta_q <= {resistor_disable_in_i, write_protect_pin_i,
                buffer_in_b_i, buffer_in_a_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Buffers and resistor controls
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            outa_oe_q <= 1'b1;
            outb_oe_q <= 1'b1;
            res0_q <= 8'h00;
            res1_q <= 8'h00;
            hiz_q <= 1'b1;
        end
        else
        begin
            outa_oe_q <= ~outa_release;
            outb_oe_q <= ~in_b_s;
            res0_q <= tie ? lut_sel[7:0] : ctrl_q[CTRL_MAN0_LSB +: 8];
            res1_q <= tie ? lut_sel[15:8] : ctrl_q[CTRL_MAN1_LSB +: 8];
            hiz_q <= hiz_s;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o = irq_q;
    assign conv_start_o = start_q;
    assign conv_chan_o = chan_q;
    assign alarm_buffer_out_a_o = 1'b0;
    assign alarm_buffer_out_a_oe_o = outa_oe_q;
    assign buffer_out_b_o = 1'b0;
    assign buffer_out_b_oe_o = outb_oe_q;
    assign resistor0_setting_o = res0_q;
    assign resistor1_setting_o = res1_q;
    assign resistor_hiz_o = hiz_q;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_result_low_clear: assert property (
        take |=> result_q[$past(chan_q)][3:0] == 4'h0)
        else $error("result low bits not cleared");
    a_chan_advance: assert property (
        conv_start_o |-> conv_chan_o == $past(chan_q) + 2'd1)
        else $error("channel did not advance by one");
    a_start_spacing: assert property (
        conv_start_o |=> !conv_start_o [*3])
        else $error("requests too close");
    a_done_atomic: assert property (
        take |=> status_q[DONE_LSB + $past(chan_q)] &&
            result_q[$past(chan_q)] == $past(new_res))
        else $error("result and done not updated together");
    a_high_alarm_set: assert property (
        take && over_hi |=> status_q[HI_LSB + $past(chan_q)])
        else $error("high alarm not set");
    a_alarm_sticky: assert property (
        status_q[HI_LSB] && !(wr_fire && hit_status) |=> status_q[HI_LSB])
        else $error("alarm flag lost without clear");
    a_irq_masked: assert property (
        (status_q & mask_q) == 12'h000 ##1 (status_q & mask_q) == 12'h000
        |-> !irq_o)
        else $error("interrupt without enabled flag");
    a_outa_alarm: assert property (
        ctrl_q[CTRL_OUTA_ALARM_BIT] && alarm_out |=> !alarm_buffer_out_a_oe_o)
        else $error("output a not released on alarm");
    a_hiz_follow: assert property (
        $rose(resistor_disable_in_i) ##1 resistor_disable_in_i [*3]
        |-> ##1 resistor_hiz_o)
        else $error("resistors not disabled");
    a_lock_holds: assert property (
        wr_fire && hit_lim && locked |=> $stable(hi_q[CH_VCC]))
        else $error("limit written while locked");
    a_manual_mode: assert property (
        !tie ##1 !tie |-> resistor0_setting_o == $past(ctrl_q[15:8]))
        else $error("manual setting not applied");

    c_alarm_seen: cover property (take && over_hi);
    c_clear_write: cover property (wr_fire && hit_status);
    c_locked_write: cover property (wr_fire && locked);

endmodule : monitor_channels_and_alarm_outputs

// *** core/monitor_pkg.sv ***
// Constants and carrier types shared by the monitor block and its link
// receiver. Assumes a 10 MHz system clock and a 32-bit Wishbone slave port.
package monitor_pkg;

    // Clock and conversion frame timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int FRAME_PERIOD_MS = 20;
    localparam int FRAME_CYCLES = FRAME_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int NUM_CHAN = 4;

    // Channel numbers in round-robin order
    localparam logic [1:0] CH_VCC = 2'h0;
    localparam logic [1:0] CH_AIN_A = 2'h1;
    localparam logic [1:0] CH_AIN_B = 2'h2;
    localparam logic [1:0] CH_TEMP = 2'h3;

    // Register byte addresses
    localparam logic [11:0] ADR_CTRL = 12'h000;
    localparam logic [11:0] ADR_STATUS = 12'h004;
    localparam logic [11:0] ADR_MASK = 12'h008;
    localparam logic [11:0] ADR_PINS = 12'h00C;
    localparam logic [11:0] ADR_RESULT = 12'h010;
    localparam logic [11:0] ADR_LIMIT = 12'h020;
    localparam logic [11:0] ADR_LUT = 12'h100;

    // Control register fields and reset value
    localparam int CTRL_TIE_BIT = 0;
    localparam int CTRL_OUTA_ALARM_BIT = 1;
    localparam int CTRL_PROTECT_BIT = 2;
    localparam int CTRL_MAN0_LSB = 8;
    localparam int CTRL_MAN1_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] CTRL_USED = 32'h00FF_FF07;

    // Status and mask layout: done, high alarm, low alarm per channel
    localparam int DONE_LSB = 0;
    localparam int HI_LSB = 4;
    localparam int LO_LSB = 8;
    localparam int STATUS_W = 12;
    localparam logic [11:0] STATUS_RESET = 12'h000;
    localparam logic [11:0] ALARM_BITS = 12'hFF0;

    // Result format and limit reset values
    localparam logic [15:0] RESULT_KEEP = 16'hFFF0;
    localparam logic [15:0] HI_RESET_UNS = 16'hFFF0;
    localparam logic [15:0] LO_RESET_UNS = 16'h0000;
    localparam logic [15:0] HI_RESET_SGN = 16'h7FF0;
    localparam logic [15:0] LO_RESET_SGN = 16'h8000;

    // Temperature-indexed resistor table
    localparam int TEMP_MIN_C = -40;
    localparam int TEMP_MAX_C = 102;
    localparam int TEMP_STEP_C = 2;
    localparam int LUT_DEPTH = (TEMP_MAX_C - TEMP_MIN_C) / TEMP_STEP_C + 1;
    localparam logic [15:0] LUT_RESET = 16'h0000;

    // Converter link word length
    localparam logic [4:0] LINK_WORD_BITS = 5'd16;

    // Wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_type;

    // One converted word from the link
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } conv_word_type;

endpackage : monitor_pkg

// *** core/result_link_rx.sv ***
// Receiver for converter result words on a slow serial link.
// Assumes link clock, frame and data arrive unsynchronised; data is
// stable at each rising link clock edge while frame is high, MSB first.
`timescale 1ns/1ps
module result_link_rx
    import monitor_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Link pins
    input wire logic link_sclk_i,
    input wire logic link_frame_i,
    input wire logic link_data_i,
    // Received word
    output monitor_pkg::conv_word_type word_o
);
    import monitor_pkg::*;

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic sclk_prev_q;
    logic frame_prev_q;
    logic [15:0] shift_q;
    logic [4:0] count_q;
    conv_word_type word_q;

    wire sclk_rise = sync_q[2] & ~sclk_prev_q;
    wire frame_fall = frame_prev_q & ~sync_q[1];
    wire count_full = count_q == 5'd31;

    // Two flip-flops on every link pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end
        else
        begin
            meta_q <= {link_sclk_i, link_frame_i, link_data_i};
            sync_q <= meta_q;
        end
    end

    // Shift bits on link clock edges, hand over a whole word at frame end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_prev_q <= 1'b0;
            frame_prev_q <= 1'b0;
            shift_q <= 16'h0000;
            count_q <= 5'd0;
            word_q <= '0;
        end
        else
        begin
            sclk_prev_q <= sync_q[2];
            frame_prev_q <= sync_q[1];
            word_q.valid <= frame_fall && count_q == LINK_WORD_BITS;
            if (frame_fall)
                word_q.data <= shift_q;
            if (!sync_q[1])
                count_q <= 5'd0;
            else if (sclk_rise)
            begin
                shift_q <= {shift_q[14:0], sync_q[0]};
                count_q <= count_full ? count_q : count_q + 5'd1;
            end
        end
    end

    assign word_o = word_q;

endmodule : result_link_rx
